// ---- cfg_status_pkg.sv ----
/*
 * Constants and carrier types for the status word and revision byte
 * of a bus function's configuration space.
 * Assumes the event sources sit on the same clock as the register bank.
 */
//
// Contract
// R1 - Parity error seen sets bit 15 always
// R2 - Driving system error sets bit 14
// R3 - Master abort, not special cycle, sets 13
// R4 - Target abort received as master sets 12
// R5 - Target abort signalled as target sets 11
// R6 - Timing field encodes fast/medium/slow; medium after reset
// R7 - Timing bits 10:9 read-only, medium response
// R8 - Master parity error needs master, PERR, enable
// R9 - Back-to-back capable bit 7 reads zero
// R10 - Speed bit 5 reads zero, 33 MHz
// R11 - Capability list bit 4 reads one
// R12 - Status word at 06h, 16 bits, read-only
// R13 - Revision byte at 08h, read-only
// R14 - Reserved status bits read zero
package cfg_status_pkg;
    // Register offsets
    localparam logic [7:0] status_offset   = 8'h06;
    localparam logic [7:0] revision_offset = 8'h08;
    // Bit positions in the status word
    localparam int parity_error_seen_pos        = 15;
    localparam int system_error_signalled_pos   = 14;
    localparam int master_abort_received_pos    = 13;
    localparam int target_abort_received_pos    = 12;
    localparam int target_abort_signalled_pos   = 11;
    localparam int timing_hi_pos                = 10;
    localparam int timing_lo_pos                = 9;
    localparam int master_data_parity_error_pos = 8;
    localparam int back_to_back_capable_pos     = 7;
    localparam int double_speed_capable_pos     = 5;
    localparam int capability_list_present_pos  = 4;
    // Timing field encodings
    localparam logic [1:0] timing_fast   = 2'h0;
    localparam logic [1:0] timing_medium = 2'h1;
    localparam logic [1:0] timing_slow   = 2'h2;
    // Fixed capability values
    localparam logic back_to_back_capable_value    = 1'h0;
    localparam logic double_speed_capable_value    = 1'h0;
    localparam logic capability_list_present_value = 1'h1;
    // Revision code; value arbitrary
    localparam logic [7:0] design_revision_default = 8'h5A;
    // Status word after reset: medium timing, capability list present
    localparam logic [15:0] status_reset_value = 16'h0210;
    // Reserved positions of the status word, bits 6 and 3 to 0
    localparam logic [15:0] status_reserved_mask = 16'h004F;

    // Bus events reported by the rest of the function, one-cycle pulses
    typedef struct packed {
        logic parity_error;      // Any parity error detected
        logic serr_driven;       // System error driven
        logic master_abort;      // Own transaction ended in master abort
        logic special_cycle;     // That transaction was a special cycle
        logic target_abort_rx;   // Own transaction ended by target abort
        logic target_abort_tx;   // We ended a transaction as target
        logic perr_as_master;    // PERR driven on read / seen on write
        logic acting_master;     // We were master for that data phase
    } bus_event_type;
endpackage : cfg_status_pkg

// ---- cfg_status_regs.sv ----
/*
 * Status word and revision byte of a configuration space header.
 * Assumes a config read port on the bus clock; event pulses are
 * synchronous to that clock and come from the function's own logic.
 */
`timescale 1ns/1ps
`default_nettype none
module cfg_status_regs #(
    parameter logic [7:0] revision = cfg_status_pkg::design_revision_default
) (
    input  wire logic                         clock,          // Bus clock
    input  wire logic                         rst,            // Sync reset
    input  wire cfg_status_pkg::bus_event_type events,        // Event pulses
    input  wire logic                         parity_response_enable, // Cmd 6
    input  wire logic                         clear_write,    // Config write
    input  wire logic [7:0]                   cfg_addr,       // Byte offset
    input  wire logic                         cfg_read,       // Read strobe
    output logic      [15:0]                  status_word,    // Live status
    output logic      [15:0]                  read_data,      // Read data
    output logic                              read_valid      // Read answer
);
    // Sticky event flags
    logic parity_error_seen, next_parity_error_seen;
    logic system_error_signalled, next_system_error_signalled;
    logic master_abort_received, next_master_abort_received;
    logic target_abort_received, next_target_abort_received;
    logic target_abort_signalled, next_target_abort_signalled;
    logic master_data_parity_error, next_master_data_parity_error;
    logic [15:0] next_status_word;   // Assembled word
    logic [15:0] next_read_data;     // Read mux
    logic        next_read_valid;    // Read answer

    // Flags set on events; writes never clear them (read-only word)
    always_comb begin
        next_parity_error_seen = parity_error_seen
            | events.parity_error;                       // see R1
        next_system_error_signalled = system_error_signalled
            | events.serr_driven;                        // see R2
        next_master_abort_received = master_abort_received
            | (events.master_abort & ~events.special_cycle); // see R3
        next_target_abort_received = target_abort_received
            | events.target_abort_rx;                    // see R4
        next_target_abort_signalled = target_abort_signalled
            | events.target_abort_tx;                    // see R5
        next_master_data_parity_error = master_data_parity_error
            | (events.perr_as_master & events.acting_master
               & parity_response_enable);                // see R8
    end

    // Word assembly; reserved bits stay zero
    always_comb begin
        next_status_word = 16'h0000;                     // see R14
        next_status_word[cfg_status_pkg::parity_error_seen_pos] =
            next_parity_error_seen;
        next_status_word[cfg_status_pkg::system_error_signalled_pos] =
            next_system_error_signalled;
        next_status_word[cfg_status_pkg::master_abort_received_pos] =
            next_master_abort_received;
        next_status_word[cfg_status_pkg::target_abort_received_pos] =
            next_target_abort_received;
        next_status_word[cfg_status_pkg::target_abort_signalled_pos] =
            next_target_abort_signalled;
        next_status_word[cfg_status_pkg::timing_hi_pos:
                         cfg_status_pkg::timing_lo_pos] =
            cfg_status_pkg::timing_medium;               // see R6, R7
        next_status_word[cfg_status_pkg::master_data_parity_error_pos] =
            next_master_data_parity_error;
        next_status_word[cfg_status_pkg::back_to_back_capable_pos] =
            cfg_status_pkg::back_to_back_capable_value;  // see R9
        next_status_word[cfg_status_pkg::double_speed_capable_pos] =
            cfg_status_pkg::double_speed_capable_value;  // see R10
        next_status_word[cfg_status_pkg::capability_list_present_pos] =
            cfg_status_pkg::capability_list_present_value; // see R11
    end

    // Read decode; unmapped offsets return zero
    always_comb begin
        next_read_valid = cfg_read;
        next_read_data  = 16'h0000;
        if (cfg_read) begin
            unique case (cfg_addr)
                cfg_status_pkg::status_offset:   begin
                    next_read_data = next_status_word;   // see R12
                end
                cfg_status_pkg::revision_offset: begin
                    next_read_data = {8'h00, revision};  // see R13
                end
                default: begin
                    next_read_data = 16'h0000;
                end
            endcase
        end
    end

    // Register everything
    always_ff @(posedge clock) begin
        if (rst) begin
            parity_error_seen        <= 1'h0;
            system_error_signalled   <= 1'h0;
            master_abort_received    <= 1'h0;
            target_abort_received    <= 1'h0;
            target_abort_signalled   <= 1'h0;
            master_data_parity_error <= 1'h0;
            status_word              <= cfg_status_pkg::status_reset_value;
            read_data                <= 16'h0000;
            read_valid               <= 1'h0;
        end else begin
            parity_error_seen        <= next_parity_error_seen;
            system_error_signalled   <= next_system_error_signalled;
            master_abort_received    <= next_master_abort_received;
            target_abort_received    <= next_target_abort_received;
            target_abort_signalled   <= next_target_abort_signalled;
            master_data_parity_error <= next_master_data_parity_error;
            status_word              <= next_status_word;
            read_data                <= next_read_data;
            read_valid               <= next_read_valid;
        end
    end

    // Checks on the word as software sees it, one cycle after each event

    // Parity flag follows any detected parity error
    property p_parity_seen;
        @(posedge clock) disable iff (rst)
        events.parity_error |=>
            status_word[cfg_status_pkg::parity_error_seen_pos];
    endproperty
    a_parity_seen: assert property (p_parity_seen) // see R1
        else $error("parity flag not set");

    // Parity flag holds until reset, since the word is read-only
    property p_parity_sticky;
        @(posedge clock) disable iff (rst)
        status_word[cfg_status_pkg::parity_error_seen_pos] |=>
            status_word[cfg_status_pkg::parity_error_seen_pos];
    endproperty
    a_parity_sticky: assert property (p_parity_sticky) // see R1
        else $error("parity flag dropped");

    // System error flag follows each driven system error
    property p_serr;
        @(posedge clock) disable iff (rst)
        events.serr_driven |=>
            status_word[cfg_status_pkg::system_error_signalled_pos];
    endproperty
    a_serr: assert property (p_serr) // see R2
        else $error("system error flag not set");

    // Master abort on a special cycle leaves the flag alone
    property p_master_abort;
        @(posedge clock) disable iff (rst)
        (!status_word[cfg_status_pkg::master_abort_received_pos]
         && events.master_abort && events.special_cycle
         && !$past(events.master_abort)) |=>
            !status_word[cfg_status_pkg::master_abort_received_pos];
    endproperty
    a_master_abort: assert property (p_master_abort) // see R3
        else $error("special cycle abort set flag");

    // Ordinary master abort sets the flag
    property p_master_abort_set;
        @(posedge clock) disable iff (rst)
        (events.master_abort && !events.special_cycle) |=>
            status_word[cfg_status_pkg::master_abort_received_pos];
    endproperty
    a_master_abort_set: assert property (p_master_abort_set) // see R3
        else $error("master abort flag not set");

    // Received target abort sets its flag
    property p_target_abort_rx;
        @(posedge clock) disable iff (rst)
        events.target_abort_rx |=>
            status_word[cfg_status_pkg::target_abort_received_pos];
    endproperty
    a_target_abort_rx: assert property (p_target_abort_rx) // see R4
        else $error("received target abort flag not set");

    // Signalled target abort sets its flag, which holds for the following cycle too
    property p_target_abort_tx;
        @(posedge clock) disable iff (rst)
        events.target_abort_tx |=>
            status_word[cfg_status_pkg::target_abort_signalled_pos] [*2];
    endproperty
    a_target_abort_tx: assert property (p_target_abort_tx) // see R5
        else $error("signalled target abort flag not held");

    // Timing field fixed at the medium code
    property p_timing;
        @(posedge clock) disable iff (rst)
        status_word[cfg_status_pkg::timing_hi_pos:
                    cfg_status_pkg::timing_lo_pos]
            == cfg_status_pkg::timing_medium;
    endproperty
    a_timing: assert property (p_timing) // see R6
        else $error("timing field not medium");

    // Parity error reported on a data phase that we mastered
    sequence s_master_perr;
        events.perr_as_master && events.acting_master;
    endsequence

    // With parity response off, the master parity flag stays clear
    property p_parity_gate;
        @(posedge clock) disable iff (rst)
        (s_master_perr and !parity_response_enable
         and !status_word[cfg_status_pkg::master_data_parity_error_pos])
            |=> !status_word[cfg_status_pkg::master_data_parity_error_pos];
    endproperty
    a_parity_gate: assert property (p_parity_gate) // see R8
        else $error("data parity flag set while disabled");

    // With parity response on, the master parity flag sets
    property p_parity_master;
        @(posedge clock) disable iff (rst)
        (s_master_perr and parity_response_enable) |=>
            status_word[cfg_status_pkg::master_data_parity_error_pos];
    endproperty
    a_parity_master: assert property (p_parity_master) // see R8
        else $error("data parity flag not set");

    // Fixed capability bits and reserved bits
    property p_fixed_bits;
        @(posedge clock) disable iff (rst)
        status_word[cfg_status_pkg::back_to_back_capable_pos]
            == cfg_status_pkg::back_to_back_capable_value
        && status_word[cfg_status_pkg::double_speed_capable_pos]
            == cfg_status_pkg::double_speed_capable_value
        && status_word[cfg_status_pkg::capability_list_present_pos]
            == cfg_status_pkg::capability_list_present_value
        && (status_word & cfg_status_pkg::status_reserved_mask) == 16'h0000;
    endproperty
    a_fixed_bits: assert property (p_fixed_bits) // see R14
        else $error("fixed status bit wrong");

    // Revision read answers with the revision byte
    property p_read_revision;
        @(posedge clock) disable iff (rst)
        (cfg_read && cfg_addr == cfg_status_pkg::revision_offset) |=>
            read_valid && read_data == {8'h00, revision};
    endproperty
    a_read_revision: assert property (p_read_revision) // see R13
        else $error("revision read wrong");

    // Every read strobe gets its answer cycle
    property p_read_answer;
        @(posedge clock) disable iff (rst)
        cfg_read |=> read_valid;
    endproperty
    a_read_answer: assert property (p_read_answer) // see R12
        else $error("read not answered");

    // No answer without a read strobe
    property p_read_idle;
        @(posedge clock) disable iff (rst)
        !cfg_read |=> !read_valid;
    endproperty
    a_read_idle: assert property (p_read_idle) // see R12
        else $error("answer without read");
endmodule : cfg_status_regs
`default_nettype wire

// ---- cfg_event_source.sv ----
/* Event source standing in for the function's own bus logic.
   Assumes it shares the register bank's clock; drives at falling edge. */
`timescale 1ns/1ps
`default_nettype none
module cfg_event_source (
    input  wire logic                          clock,  // Bus clock
    output var  cfg_status_pkg::bus_event_type events  // Event pulses
);
    // Idle with no event raised
    initial begin
        events = '0;
    end

    // One-cycle pulse, raised and dropped at falling edges
    task automatic pulse(input cfg_status_pkg::bus_event_type e);
        @(negedge clock);
        events = e;
        @(negedge clock);
        events = '0;
    endtask : pulse
endmodule : cfg_event_source
`default_nettype wire

// ---- pci_config_status_revision_tb.sv ----
/* Self-checking bench for the status word and revision byte.
   Assumes the design's default revision value; no long waits. */
`timescale 1ns/1ps
`default_nettype none
module pci_config_status_revision_tb;
    logic                          clock     = 1'h0;  // Bus clock
    logic                          rst       = 1'h1;  // Sync reset
    logic                          parity_en = 1'h0;  // Parity response
    logic                          clr_wr    = 1'h0;  // Ignored write
    logic [7:0]                    addr      = 8'h00; // Read offset
    logic                          rd        = 1'h0;  // Read strobe
    logic [15:0]                   exp_word;          // Expected word
    cfg_status_pkg::bus_event_type ev;             // Event pulses
    logic [15:0]                   st_word;        // Live status
    logic [15:0]                   data;           // Read answer
    logic                          valid;          // Answer strobe
    int                            errors = 0;     // Mismatches
    int                            checks_done = 0; // Comparisons
    // Event, enable and expected word per case, case i at slice i
    localparam logic [71:0]  ev_tab =
        72'h02_03_03_04_08_30_20_40_80;
    localparam logic [8:0]   en_tab = 9'h140;
    localparam logic [143:0] ex_tab =
        144'h0210_0210_0310_0A10_1210_0210_2210_4210_8210;
    localparam logic [15:0] rev_word =
        {8'h00, cfg_status_pkg::design_revision_default};

    cfg_event_source i_src (.clock(clock), .events(ev));

    cfg_status_regs i_dut (
        .clock(clock), .rst(rst), .events(ev),
        .parity_response_enable(parity_en), .clear_write(clr_wr),
        .cfg_addr(addr), .cfg_read(rd), .status_word(st_word),
        .read_data(data), .read_valid(valid));

    // Free-running clock, 10 ns period
    always #5 clock = ~clock;

    // Compare and count
    task automatic check(input string what, input logic [15:0] expv,
                         input logic [15:0] got);
        checks_done++;
        if (got !== expv) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, expv, got);
        end
    endtask : check

    // Read at a falling edge; rd stays up unless last, for back to back
    task automatic read_reg(input logic [7:0] a, input logic [15:0] expv,
                            input logic last);
        addr = a;
        rd = 1'h1;
        @(negedge clock);
        if (last) begin
            rd = 1'h0;
        end
        check("read_valid", 16'h0001, {15'h0000, valid});
        check("read_data", expv, data);
    endtask : read_reg

    // Reset held for six cycles
    task automatic do_reset;
        rst = 1'h1;
        repeat (6) @(negedge clock);
        rst = 1'h0;
    endtask : do_reset

    // Verdict and end of run
    task automatic conclude;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    // Watchdog against a hang
    initial begin
        #100us;
        errors++;
        conclude();
    end

    // Main sequence
    initial begin
        do_reset();
        check("status_word", 16'h0210, st_word);
        read_reg(8'h06, 16'h0210, 1'h0);
        read_reg(8'h08, rev_word, 1'h0);
        read_reg(8'h07, 16'h0000, 1'h0);
        read_reg(8'h0A, 16'h0000, 1'h1);
        @(negedge clock);
        check("read_valid", 16'h0000, {15'h0000, valid});
        check("read_data", 16'h0000, data);
        $display("test reset values done");
        for (int i = 0; i < 9; i++) begin
            do_reset();
            parity_en = en_tab[i];
            exp_word = ex_tab[i*16 +: 16];
            i_src.pulse(cfg_status_pkg::bus_event_type'(ev_tab[i*8 +: 8]));
            check("status_word", exp_word, st_word);
            clr_wr = 1'h1;
            read_reg(8'h06, exp_word, 1'h0);
            clr_wr = 1'h0;
            read_reg(8'h06, exp_word, 1'h0);
            read_reg(8'h08, rev_word, 1'h1);
            $display("test event case %0d done", i);
        end
        conclude();
    end
endmodule : pci_config_status_revision_tb
`default_nettype wire
